// ### aecm_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Write and read may occur in the same cycle
`timescale 1ns/1ps
`default_nettype none
module aecm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             clr,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp;
    logic [AW:0]      rp;
    logic [AW:0]      next_wp;
    logic [AW:0]      next_rp;
    logic             wr;
    logic             rd;

    assign in_ready  = (wp - rp) != (AW+1)'(DEPTH);
    assign out_valid = wp != rp;
    assign out_data  = mem[rp[AW-1:0]];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_comb begin
        next_wp = clr ? '0 : wp + (AW+1)'(wr);
        next_rp = clr ? '0 : rp + (AW+1)'(rd);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule : aecm_fifo
`default_nettype wire

// ### aecm_monitor.sv
// Purpose: Captures address events by req/ack, stamps them, ships full buffers
// Assumes: Sender inputs are asynchronous; USB side is a byte stream with ready
// Notes:   A 16-word FIFO decouples capture from the 225-event packet buffer
`timescale 1ns/1ps
`default_nettype none
module aecm_monitor
    import aecm_pkg::*;
#(
    parameter int XFER_CYCLES = aecm_pkg::XFER_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Event sender
    input  wire logic              req_n,
    input  wire logic [15:0]       addr_in,
    output logic                   ack_n,
    // Host link
    input  wire logic              host_open,
    output logic                   usb_valid,
    output logic [7:0]             usb_data,
    input  wire logic              usb_ready,
    // Indicators
    output logic                   led_activity,
    output logic                   led_transfer
);
    import aecm_pkg::*;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_ACK  = 2'b01,
        HS_WAIT = 2'b10
    } aecm_hs_t;

    typedef enum logic [1:0] {
        TX_FILL = 2'b00,
        TX_SEND = 2'b01,
        TX_HOLD = 2'b10
    } aecm_tx_t;

    // Three-stage synchronisers; only stages two and three are examined
    logic [2:0]  req_s;
    logic        req_seen;
    logic        next_req_seen;
    logic [2:0]  open_s;
    logic        opened;
    logic        next_opened;
    always_comb begin
        next_req_seen = (req_s[1] == req_s[2]) ? !req_s[2] : req_seen;
        next_opened   = (open_s[1] == open_s[2]) ? open_s[2] : opened;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_s    <= 3'h7;
            req_seen <= 1'b0;
            open_s   <= 3'h0;
            opened   <= 1'b0;
        end else begin
            req_s    <= {req_s[1:0], req_n};
            req_seen <= next_req_seen;
            open_s   <= {open_s[1:0], host_open};
            opened   <= next_opened;
        end
    end
    wire open_rise = next_opened && !opened;

    // Microsecond timestamp
    logic [4:0]  div;
    logic [4:0]  next_div;
    logic [15:0] ts;
    logic [15:0] next_ts;
    always_comb begin
        next_div = (div == 5'(TICK_CYC - 1)) ? 5'h00 : div + 5'h01;
        next_ts  = ts;
        if (open_rise) begin
            next_ts  = TS_RESET;
            next_div = 5'h00;
        end else if (div == 5'(TICK_CYC - 1)) begin
            next_ts = ts + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div <= 5'h00;
            ts  <= TS_RESET;
        end else begin
            div <= next_div;
            ts  <= next_ts;
        end
    end

    // Handshake with sender
    aecm_hs_t    hs;
    aecm_hs_t    next_hs;
    aecm_event_t cap;
    aecm_event_t next_cap;
    logic        next_ack_n;
    logic        next_led_act;
    logic        push;
    logic        fifo_in_ready;
    logic        xfer_busy;
    aecm_tx_t    tx;
    always_comb begin
        next_hs      = hs;
        next_cap     = cap;
        next_ack_n   = ack_n;
        next_led_act = led_activity;
        push         = 1'b0;
        unique case (hs)
            HS_IDLE: begin
                if (req_seen) begin
                    next_led_act = 1'b1;
                    // Address settled well before req passed the synchroniser
                    next_cap = '{addr: addr_in, ts: ts};
                    next_hs  = HS_ACK;
                end
            end
            HS_ACK: begin
                // Unopened: ack at once and drop; opened: wait FIFO and transfer
                if (!opened) begin
                    next_ack_n   = 1'b0;
                    next_led_act = 1'b0;
                    next_hs      = HS_WAIT;
                end else if (!xfer_busy && fifo_in_ready) begin
                    push         = 1'b1;
                    next_ack_n   = 1'b0;
                    next_led_act = 1'b0;
                    next_hs      = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (!req_seen) begin
                    next_ack_n = 1'b1;
                    next_hs    = HS_IDLE;
                end
            end
            default: next_hs = HS_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hs           <= HS_IDLE;
            cap          <= '0;
            ack_n        <= 1'b1;
            led_activity <= 1'b0;
        end else begin
            hs           <= next_hs;
            cap          <= next_cap;
            ack_n        <= next_ack_n;
            led_activity <= next_led_act;
        end
    end

    // FIFO between capture and packet buffer
    logic        f_valid;
    logic        f_ready;
    aecm_event_t f_data;
    aecm_fifo #(
        .WIDTH ($bits(aecm_event_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .clr       (open_rise),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (cap),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // Packet buffer and USB shipping
    aecm_event_t buf_mem [BUF_EVENTS];
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic [9:0]  byte_idx;
    logic [9:0]  next_byte_idx;
    aecm_tx_t    next_tx;
    logic [15:0] hold;
    logic [15:0] next_hold;
    logic        next_led_xfer;
    logic [7:0]  next_usb_data;
    logic        next_usb_valid;
    aecm_event_t cur;
    logic [1:0]  lane;
    assign xfer_busy = (tx != TX_FILL);
    assign f_ready   = (tx == TX_FILL);
    assign cur       = buf_mem[8'(byte_idx >> 2)];
    assign lane      = byte_idx[1:0];
    always_comb begin
        next_tx        = tx;
        next_cnt       = cnt;
        next_byte_idx  = byte_idx;
        next_hold      = hold;
        next_led_xfer  = led_transfer;
        next_usb_valid = usb_valid;
        next_usb_data  = usb_data;
        unique case (tx)
            TX_FILL: begin
                if (f_valid) begin
                    next_cnt = cnt + 8'h01;
                    if (cnt == 8'(BUF_EVENTS - 1)) begin
                        next_tx       = TX_SEND;
                        next_byte_idx = 10'h000;
                        next_hold     = 16'(XFER_CYCLES);
                        next_led_xfer = !led_transfer;
                    end
                end
            end
            TX_SEND: begin
                if (hold != 16'h0000) begin
                    next_hold = hold - 16'h0001;
                end
                if (!usb_valid || usb_ready) begin
                    if (usb_valid && byte_idx == 10'(BUF_BYTES)) begin
                        next_usb_valid = 1'b0;
                        next_tx        = TX_HOLD;
                    end else if (byte_idx != 10'(BUF_BYTES)) begin
                        next_usb_valid = 1'b1;
                        unique case (lane)
                            2'h0: next_usb_data = cur.addr[15:8];
                            2'h1: next_usb_data = cur.addr[7:0];
                            2'h2: next_usb_data = cur.ts[15:8];
                            default: next_usb_data = cur.ts[7:0];
                        endcase
                        next_byte_idx = byte_idx + 10'h001;
                    end
                end
            end
            TX_HOLD: begin
                // Transfer window lasts at least the nominal USB time
                if (hold != 16'h0000) begin
                    next_hold = hold - 16'h0001;
                end else begin
                    next_tx  = TX_FILL;
                    next_cnt = 8'h00;
                end
            end
            default: next_tx = TX_FILL;
        endcase
        if (open_rise) begin
            next_cnt = 8'h00;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx           <= TX_FILL;
            cnt          <= 8'h00;
            byte_idx     <= 10'h000;
            hold         <= 16'h0000;
            led_transfer <= 1'b0;
            usb_valid    <= 1'b0;
            usb_data     <= 8'h00;
        end else begin
            tx           <= next_tx;
            cnt          <= next_cnt;
            byte_idx     <= next_byte_idx;
            hold         <= next_hold;
            led_transfer <= next_led_xfer;
            usb_valid    <= next_usb_valid;
            usb_data     <= next_usb_data;
        end
    end
    always_ff @(posedge clk) begin
        if (tx == TX_FILL && f_valid) begin
            buf_mem[cnt] <= f_data;
        end
    end

    // Checks
    sequence ack_given_s;
        $fell(ack_n);
    endsequence
    no_ack_xfer_a: assert property (@(posedge clk) disable iff (!rstn)
        (hs == HS_ACK && opened && xfer_busy) |=> ack_n)
        else $error("ack given during transfer");
    ack_fast_a: assert property (@(posedge clk) disable iff (!rstn)
        (hs == HS_ACK && !opened) |=> !ack_n)
        else $error("unopened handshake not acked");
    led_low_ack_a: assert property (@(posedge clk) disable iff (!rstn)
        ack_given_s |-> !led_activity)
        else $error("activity led high after ack");
    led_xfer_a: assert property (@(posedge clk) disable iff (!rstn)
        (tx == TX_FILL && f_valid && cnt == 8'(BUF_EVENTS - 1)) |=> $changed(led_transfer))
        else $error("transfer led did not toggle");
    ts_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        open_rise |=> ts == TS_RESET)
        else $error("timestamp not cleared on open");
    ts_tick_a: assert property (@(posedge clk) disable iff (!rstn)
        (!open_rise && div == 5'(TICK_CYC - 1)) |=> ts == $past(ts) + 16'h0001)
        else $error("timestamp tick wrong");
    ack_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        (hs == HS_WAIT && req_seen) |=> !ack_n)
        else $error("ack released while request held");
    cap_addr_a: assert property (@(posedge clk) disable iff (!rstn)
        (hs == HS_IDLE && req_seen) |=> cap.addr == $past(addr_in) && cap.ts == $past(ts))
        else $error("capture mismatch");
    usb_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (usb_valid && !usb_ready) |=> usb_valid && $stable(usb_data))
        else $error("usb byte dropped while stalled");
endmodule : aecm_monitor
`default_nettype wire

// ### aecm_monitor_tb.sv
// Purpose: Self-checking bench for the address-event capture monitor
// Assumes: Short transfer hold so the run stays brief
// Notes:   USB sink stalls on demand; record addresses checked exactly, timestamps within one tick
`timescale 1ns/1ps
`default_nettype none
module aecm_monitor_tb;
    import aecm_pkg::*;
    localparam int XC = 50;
    // Host driver buffer depth in events; beyond it the host flags an overrun
    localparam int HOST_EVENTS = 16384;
    logic        clk;
    logic        rstn;
    logic        req_n;
    logic [15:0] addr_in;
    logic        ack_n;
    logic        host_open;
    logic        usb_valid;
    logic [7:0]  usb_data;
    logic        usb_ready;
    logic        led_activity;
    logic        led_transfer;
    logic        lt_q;
    logic        ack_q;
    bit          stall;
    bit          busy;
    bit          saw_act;
    int          err_total;
    int          cmp_count;
    int          cyc;
    int          open_cyc;
    int          xfer_cyc;
    int          ack_busy;
    logic [7:0]  rx[$];
    logic [15:0] exp_a[$];
    int          exp_t[$];

    aecm_monitor #(.XFER_CYCLES(XC)) dut (.clk(clk), .rstn(rstn), .req_n(req_n),
        .addr_in(addr_in), .ack_n(ack_n), .host_open(host_open), .usb_valid(usb_valid),
        .usb_data(usb_data), .usb_ready(usb_ready), .led_activity(led_activity),
        .led_transfer(led_transfer));
    aecm_sender snd (.clk(clk), .req_n(req_n), .addr_in(addr_in), .ack_n(ack_n));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Sink, transfer window tracking and acknowledge watch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (usb_valid === 1'b1 && usb_ready === 1'b1) rx.push_back(usb_data);
        usb_ready <= #1 stall ? cyc[2] : 1'b1;
        lt_q <= led_transfer;
        ack_q <= ack_n;
        if (rstn && led_transfer !== lt_q) begin
            busy <= 1'b1;
            xfer_cyc <= cyc;
        end else if (busy && rx.size() % BUF_BYTES == 0 && cyc - xfer_cyc >= XC - 2) begin
            busy <= 1'b0;
        end
        if (busy && ack_n === 1'b0 && ack_q === 1'b1) ack_busy <= ack_busy + 1;
        if (req_n === 1'b0 && led_activity === 1'b1) saw_act <= 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic burst(input int n, input int gap, input bit store, input int lim);
        int c;
        bit ok;
        logic [15:0] a;
        for (int i = 0; i < n; i++) begin
            a = (i == 1) ? 16'hffff : 16'(i * 40503);
            if (store) begin
                exp_a.push_back(a);
                exp_t.push_back((cyc + 1 - open_cyc) / TICK_CYC);
            end
            snd.send(a, (i < 4) ? 6 : gap, lim, c, ok);
            check("hs_cycles", c < lim, 1);
            if (!ok) summarize();
        end
    endtask : burst

    task automatic open_host();
        host_open = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        host_open = 1'b1;
        open_cyc  = cyc;
        exp_a.delete();
        exp_t.delete();
        repeat (8) @(posedge clk);
        #1;
    endtask : open_host

    task automatic wait_rx(input int n);
        int k;
        k = 0;
        while ((rx.size() < n || busy) && k < 20000) begin
            @(posedge clk);
            k++;
        end
        #1;
        check("rx_bytes", rx.size(), n);
        check("overrun", (rx.size() / EVT_BYTES) > HOST_EVENTS, 1'b0);
        // A transfer that never finishes must not slip through as a pass
        check("rx_in_time", k < 20000, 1);
        if (k >= 20000) summarize();
    endtask : wait_rx

    task automatic check_records(input int base);
        for (int i = 0; i < BUF_EVENTS; i++) begin
            int d;
            check("addr", {rx[base+4*i], rx[base+4*i+1]}, exp_a[i]);
            d = int'({rx[base+4*i+2], rx[base+4*i+3]}) - exp_t[i];
            check("ts", d >= -1 && d <= 1, 1);
        end
    endtask : check_records

    // Closed device: quick handshakes, nothing stored or shipped
    task automatic s_unopened();
        burst(20, 0, 1'b0, TICK_CYC + 1);
        repeat (100) @(posedge clk);
        #1;
        check("rx_empty", rx.size(), 0);
        check("led_xfer_off", led_transfer, 1'b0);
        check("act_seen", saw_act, 1'b1);
        check("act_low", led_activity, 1'b0);
    endtask : s_unopened

    // Full buffer of events, first few with a slow sender
    task automatic s_fill();
        open_host();
        burst(BUF_EVENTS, 0, 1'b1, CYCLE_MAX + 1);
        wait_rx(BUF_BYTES);
        check("led_xfer_on", led_transfer, 1'b1);
        check_records(0);
    endtask : s_fill

    // Reopen, overfill while the sink stalls: requests must wait out the transfer
    task automatic s_stall();
        open_host();
        stall = 1'b1;
        burst(BUF_EVENTS + 15, 0, 1'b1, 5000);
        wait_rx(2 * BUF_BYTES);
        stall = 1'b0;
        check("ack_in_xfer", ack_busy, 0);
        check("led_xfer_again", led_transfer, 1'b0);
        check_records(BUF_BYTES);
    endtask : s_stall

    initial begin
        rstn      = 1'b0;
        host_open = 1'b0;
        usb_ready = 1'b1;
        lt_q      = 1'b0;
        ack_q     = 1'b1;
        cyc       = 0;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        s_unopened();
        s_fill();
        s_stall();
        summarize();
    end
endmodule : aecm_monitor_tb
`default_nettype wire

// ### aecm_pkg.sv
// Purpose: Shared constants and types for the address-event capture monitor
// Assumes: 20 MHz clock, one clock domain
// Notes:   Event record is address then timestamp, four bytes
package aecm_pkg;
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          TICK_US        = 1;
    localparam int          TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
    localparam int          ADDR_W         = 16;
    localparam int          TS_W           = 16;
    localparam int          BUF_BYTES      = 900;
    localparam int          EVT_BYTES      = 4;
    localparam int          BUF_EVENTS     = BUF_BYTES / EVT_BYTES;
    localparam int          XFER_US        = 860;
    localparam int          XFER_CYC       = XFER_US * CLK_HZ / 1_000_000;
    localparam int          CYCLE_NS       = 4300;
    localparam int          CYCLE_MAX      = CYCLE_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int          FIFO_DEPTH     = 16;
    localparam logic [15:0] TS_RESET       = 16'h0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [TS_W-1:0]   ts;
    } aecm_event_t;
endpackage : aecm_pkg

// ### aecm_sender.sv
// Purpose: Behavioural event sender facing the capture monitor
// Assumes: Four-phase handshake, request and acknowledge active low
// Notes:   Address is scrambled while idle so a stale sample cannot match
`timescale 1ns/1ps
`default_nettype none
module aecm_sender (
    // Clock
    input  wire logic        clk,
    // Handshake
    output logic             req_n,
    output logic      [15:0] addr_in,
    input  wire logic        ack_n
);
    initial begin
        req_n   = 1'b1;
        addr_in = 16'h5a5a;
    end

    // One event; cyc counts the cycles spent waiting for acknowledge and for its release
    task automatic send(input logic [15:0] a, input int gap, input int lim,
                        output int cyc, output bit ok);
        cyc = 0;
        @(posedge clk);
        #1;
        addr_in = a;
        req_n   = 1'b0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (ack_n !== 1'b0 && cyc < lim);
        // A slow sender lingers before releasing
        repeat (gap) @(posedge clk);
        #1;
        req_n   = 1'b1;
        addr_in = ~a;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (ack_n !== 1'b1 && cyc < lim);
        ok = (cyc < lim);
    endtask : send
endmodule : aecm_sender
`default_nettype wire
